// [rtl/sct_top.sv]
// Purpose: conversion start, busy, result and readout sequencing of the converter
// Assumes: host inputs come from logic on clk; only the slave serial clock is foreign
// Notes: a slave serial clock must be far slower than clk to be followed
`include "sct_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sct_top #(
	parameter int WIDTH = `SCT_WORD_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// host conversion control
	input wire logic conversion_start_n,
	input wire logic adc_reset,
	// mode straps
	input wire logic [1:0] rate_mode,
	input wire logic serial_en,
	input wire logic master_en,
	input wire logic read_during,
	input wire logic [1:0] serial_clock_divider,
	// reference selection
	input wire logic reference_powerdown,
	input wire logic ref_buffer_powerdown,
	output logic internal_ref_en,
	output logic ref_buffer_en,
	// converter core
	input wire logic [WIDTH-1:0] core_code,
	// status
	output logic busy,
	output logic result_valid,
	// parallel bus
	input wire logic cs_n,
	input wire logic rd_n,
	output logic [WIDTH-1:0] par_data_out,
	output logic par_data_oe,
	// serial port
	input wire logic ext_sclk,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic frame_marker_out,
	output logic frame_marker_oe,
	output logic serial_clock_out,
	output logic serial_clock_oe
);
	localparam int CW = `SCT_CNT_W;

	sct_pkg::sct_state_t state_r, state_nxt;
	sct_pkg::sct_rate_t rate_r, rate_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic valid_r, valid_nxt;
	logic early_r, early_nxt;
	logic start_prev_r, start_prev_nxt;
	logic [WIDTH-1:0] result_r, result_nxt;
	logic int_ref_r, int_ref_nxt;
	logic buf_en_r, buf_en_nxt;
	logic [2:0] esync_r, esync_nxt;
	logic [CW-1:0] busy_len_r;
	logic go, load, shift_ext, ser_active, ser_done, ser_sclk, ser_sdo;
	logic start_fall, rac_mode, rdc_mode, slave_mode;
	logic [CW-1:0] conv_cyc, sync_cyc;

	// ************************************************************
	// timing lookups
	// ************************************************************
	// wideband shares the fastest figures
	function automatic logic [CW-1:0] conv_cycles(input sct_pkg::sct_rate_t r);
		unique case (r)
			sct_pkg::RATE_NORM: conv_cycles = CW'(`SCT_CYC_FLOOR(`SCT_CONV_NORM_NS));
			sct_pkg::RATE_LOW: conv_cycles = CW'(`SCT_CYC_FLOOR(`SCT_CONV_LOW_NS));
			sct_pkg::RATE_FAST, sct_pkg::RATE_WIDE: begin
				conv_cycles = CW'(`SCT_CYC_FLOOR(`SCT_CONV_FAST_NS));
			end
		endcase
	endfunction

	// frame marker delay, read during or after convert
	function automatic logic [CW-1:0] sync_cycles(input sct_pkg::sct_rate_t r, input logic rdc);
		unique case (r)
			sct_pkg::RATE_NORM: begin
				sync_cycles = rdc ? CW'(`SCT_CYC_CEIL(`SCT_SYNC_RDC_NORM_NS))
					: CW'(`SCT_CYC_CEIL(`SCT_SYNC_RAC_NORM_NS));
			end
			sct_pkg::RATE_LOW: begin
				sync_cycles = rdc ? CW'(`SCT_CYC_CEIL(`SCT_SYNC_RDC_LOW_NS))
					: CW'(`SCT_CYC_CEIL(`SCT_SYNC_RAC_LOW_NS));
			end
			sct_pkg::RATE_FAST, sct_pkg::RATE_WIDE: begin
				sync_cycles = rdc ? CW'(`SCT_CYC_CEIL(`SCT_SYNC_RDC_FAST_NS))
					: CW'(`SCT_CYC_CEIL(`SCT_SYNC_RAC_FAST_NS));
			end
		endcase
	endfunction

	// half period of the internal serial clock in clk cycles
	function automatic logic [2:0] half_cycles(input logic [1:0] d);
		unique case (d)
			2'h0: half_cycles = 3'(`SCT_HALF_CYC(`SCT_SCLK_P0_NS));
			2'h1: half_cycles = 3'(`SCT_HALF_CYC(`SCT_SCLK_P1_NS));
			2'h2: half_cycles = 3'(`SCT_HALF_CYC(`SCT_SCLK_P2_NS));
			2'h3: half_cycles = 3'(`SCT_HALF_CYC(`SCT_SCLK_P3_NS));
		endcase
	endfunction

	assign rac_mode = serial_en && master_en && !read_during;
	assign rdc_mode = serial_en && master_en && read_during;
	assign slave_mode = serial_en && !master_en;
	assign start_fall = start_prev_r && !conversion_start_n;
	assign conv_cyc = conv_cycles(rate_r);
	assign sync_cyc = sync_cycles(rate_r, rdc_mode);

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	// starts while busy are dropped; the host must space them itself
	always_comb begin
		state_nxt = state_r;
		rate_nxt = rate_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		valid_nxt = valid_r;
		early_nxt = early_r;
		result_nxt = result_r;
		start_prev_nxt = conversion_start_n;
		go = 1'h0;
		load = 1'h0;
		if (adc_reset) begin
			state_nxt = sct_pkg::ST_HOLD;
			cnt_nxt = '0;
			busy_nxt = 1'h0;
			valid_nxt = 1'h0;
			early_nxt = 1'h0;
		end else begin
			unique case (state_r)
				sct_pkg::ST_IDLE: begin
					if (start_fall) begin
						state_nxt = sct_pkg::ST_CONV;
						rate_nxt = sct_pkg::sct_rate_t'(rate_mode);
						cnt_nxt = '0;
						busy_nxt = 1'h1;
					end
				end
				sct_pkg::ST_CONV: begin
					cnt_nxt = CW'(cnt_r + 1'h1);
					// read during convert ships the previous word
					if (rdc_mode && cnt_r == CW'(sync_cyc - 1'h1)) begin
						go = 1'h1;
						load = 1'h1;
					end
					if (rac_mode && cnt_r == CW'(sync_cyc - 1'h1)) begin
						early_nxt = 1'h1;
					end
					// result lands a full cycle before busy drops
					if (cnt_r == CW'(conv_cyc - 1'h1 - CW'(`SCT_EOC_CYC))) begin
						result_nxt = core_code;
						valid_nxt = 1'h1;
					end
					if (cnt_r == CW'(conv_cyc - 1'h1)) begin
						if (rac_mode) begin
							state_nxt = sct_pkg::ST_SERIAL;
							early_nxt = 1'h1;
							go = 1'h1;
							load = 1'h1;
						end else begin
							state_nxt = sct_pkg::ST_IDLE;
							busy_nxt = 1'h0;
							load = slave_mode;
						end
					end
				end
				sct_pkg::ST_SERIAL: begin
					early_nxt = 1'h0; // shifter frame has taken over
					if (ser_done) begin
						state_nxt = sct_pkg::ST_TAIL;
						cnt_nxt = '0;
					end
				end
				sct_pkg::ST_TAIL: begin
					if (cnt_r == CW'(`SCT_TAIL_CYC - 1)) begin
						state_nxt = sct_pkg::ST_IDLE;
						busy_nxt = 1'h0;
					end else begin
						cnt_nxt = CW'(cnt_r + 1'h1);
					end
				end
				sct_pkg::ST_HOLD: begin
					state_nxt = sct_pkg::ST_RSTBUSY;
					cnt_nxt = '0;
					busy_nxt = 1'h1;
				end
				sct_pkg::ST_RSTBUSY: begin
					if (cnt_r == CW'(`SCT_RST_BUSY_CYC - 1)) begin
						state_nxt = sct_pkg::ST_IDLE;
						busy_nxt = 1'h0;
					end else begin
						cnt_nxt = CW'(cnt_r + 1'h1);
					end
				end
				default: begin
					state_nxt = sct_pkg::ST_IDLE;
					busy_nxt = 1'h0;
				end
			endcase
		end
	end

	// registers only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= sct_pkg::ST_IDLE;
			rate_r <= sct_pkg::RATE_FAST;
			cnt_r <= '0;
			busy_r <= 1'h0;
			valid_r <= 1'h0;
			early_r <= 1'h0;
			result_r <= '0;
			start_prev_r <= 1'h1;
		end else begin
			state_r <= state_nxt;
			rate_r <= rate_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			valid_r <= valid_nxt;
			early_r <= early_nxt;
			result_r <= result_nxt;
			start_prev_r <= start_prev_nxt;
		end
	end

	// ************************************************************
	// reference select and slave clock synchroniser
	// ************************************************************
	// reference powerdown alone leaves the buffer on with the reference off
	always_comb begin
		int_ref_nxt = !reference_powerdown && !ref_buffer_powerdown;
		buf_en_nxt = !ref_buffer_powerdown;
		esync_nxt = {esync_r[1:0], ext_sclk};
	end

	// registers only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			int_ref_r <= 1'h0;
			buf_en_r <= 1'h0;
			esync_r <= 3'h0;
		end else begin
			int_ref_r <= int_ref_nxt;
			buf_en_r <= buf_en_nxt;
			esync_r <= esync_nxt;
		end
	end

	// stage 0 is read only by stage 1; the edge uses stages 1 and 2
	assign shift_ext = slave_mode && !cs_n && esync_r[2] && !esync_r[1];

	sct_shifter #(
		.WIDTH(WIDTH)
	) u_shifter (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(load),
		.load_data(result_r),
		.go(go),
		.shift_ext(shift_ext),
		.half_cycles(half_cycles(serial_clock_divider)),
		.fill_bit(serial_data_in),
		.active(ser_active),
		.done(ser_done),
		.sclk(ser_sclk),
		.sdo(ser_sdo)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	// enables follow chip select in the same cycle
	assign busy = busy_r;
	assign result_valid = valid_r;
	assign internal_ref_en = int_ref_r;
	assign ref_buffer_en = buf_en_r;
	assign par_data_out = result_r;
	assign par_data_oe = !serial_en && !cs_n && !rd_n;
	assign frame_marker_out = early_r || ser_active;
	assign serial_clock_out = ser_sclk;
	assign serial_data_out = ser_sdo;
	assign frame_marker_oe = serial_en && master_en && !cs_n;
	assign serial_clock_oe = serial_en && master_en && !cs_n;
	assign serial_data_oe = serial_en && !cs_n;

	// ************************************************************
	// checks
	// ************************************************************
	// helper: length of the current busy pulse
	always_ff @(posedge clk) begin
		if (sys_rst || !busy_r) begin
			busy_len_r <= '0;
		end else begin
			busy_len_r <= CW'(busy_len_r + 1'h1);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	busy_width_a: assert property ($fell(busy_r) && $past(state_r) == sct_pkg::ST_CONV
		|-> $past(busy_len_r) == CW'($past(conv_cyc) - 1'h1))
		else $error("conversion busy width wrong");
	data_first_a: assert property ($fell(busy_r) && $past(state_r) == sct_pkg::ST_CONV
		|-> $past(valid_r) && $stable(result_r))
		else $error("data not valid before busy fell");
	result_fresh_a: assert property (state_r == sct_pkg::ST_CONV && !adc_reset
		&& cnt_r == CW'(conv_cyc - 2'h2) |=> valid_r && result_r == $past(core_code))
		else $error("result not taken at conversion end");
	reset_busy_a: assert property ($fell(adc_reset) |=> busy_r[*8] ##1 busy_r[*8]
		##1 busy_r[*8] ##1 !busy_r)
		else $error("reset busy pulse wrong length");
	bus_drive_a: assert property (!serial_en && !cs_n && !rd_n
		|-> par_data_oe && par_data_out == result_r ##1 (!rd_n || !par_data_oe))
		else $error("parallel bus drive or release wrong");
	serial_float_a: assert property (cs_n
		|-> !frame_marker_oe && !serial_clock_oe && !serial_data_oe)
		else $error("serial outputs driven with chip select high");
	serial_on_a: assert property (serial_en && master_en && !cs_n
		|-> frame_marker_oe && serial_clock_oe && serial_data_oe)
		else $error("serial outputs not enabled");
	rdc_frame_a: assert property ($rose(frame_marker_out) && rdc_mode
		&& state_r == sct_pkg::ST_CONV |-> cnt_r == sync_cyc)
		else $error("read during frame marker mistimed");
	rac_frame_a: assert property ($rose(frame_marker_out) && rac_mode
		|-> cnt_r == sync_cyc)
		else $error("read after frame marker mistimed");
	tail_busy_a: assert property ($fell(frame_marker_out) && rac_mode
		&& state_r == sct_pkg::ST_TAIL |-> busy_r ##1 !busy_r)
		else $error("busy did not trail the frame marker");
	sclk_slow_a: assert property ($rose(ser_sclk) && ser_active
		&& serial_clock_divider == 2'h3 |-> ##1 ser_sclk ##1 !ser_sclk)
		else $error("slowest serial clock high phase wrong");
	ref_sel_a: assert property (reference_powerdown && ref_buffer_powerdown
		|=> !internal_ref_en && !ref_buffer_en)
		else $error("internal reference not disabled");

	par_conv_cov: cover property ($fell(busy_r) && !serial_en);
	rac_conv_cov: cover property ($fell(frame_marker_out) && rac_mode);
	rdc_conv_cov: cover property ($rose(frame_marker_out) && rdc_mode);
	reset_cov: cover property ($fell(busy_r) && $past(state_r) == sct_pkg::ST_RSTBUSY);

endmodule

`default_nettype wire

// [rtl/sct_defines.svh]
// Purpose: timing and width constants of the converter conversion timing block
// Assumes: clk runs at 40 MHz; every count below is derived from the printed time
// Notes: least times round up, longest times round down, none below one cycle
//
// Behaviour
// - busy lasts at most 283/430/560 ns
// - busy falls at least 10 ns after conversion
// - reset held 15 ns; busy 600 ns after
// - result readable right at conversion end
// - result is always a 16-bit word
// - parallel data valid before busy falls
// - bus drives data on access, releases after
// - chip select high floats serial outputs
// - chip select low enables serial outputs
// - read-during frame marker at 12/137/263 ns
// - read-after frame marker at 275/400/500 ns
// - frame marker drops, then busy 13 ns later
// - first serial clock edge after frame marker
// - reference selects: both low internal, high external
// - wideband mode times exactly like fastest mode
// - divider sets serial clock 8/16/32/64 ns; code gives 50/50/50/100 ns periods
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH

// ************************************************************
// clock and widths
// ************************************************************
`define SCT_CLK_NS 25
`define SCT_WORD_W 16
`define SCT_CNT_W 6
`define SCT_CYC_FLOOR(t) ((t) / `SCT_CLK_NS)
`define SCT_CYC_CEIL(t) (((t) + `SCT_CLK_NS - 1) / `SCT_CLK_NS)

// ************************************************************
// times in ns and their cycle counts
// ************************************************************
`define SCT_CONV_FAST_NS 283
`define SCT_CONV_NORM_NS 430
`define SCT_CONV_LOW_NS 560
`define SCT_SYNC_RDC_FAST_NS 12
`define SCT_SYNC_RDC_NORM_NS 137
`define SCT_SYNC_RDC_LOW_NS 263
`define SCT_SYNC_RAC_FAST_NS 275
`define SCT_SYNC_RAC_NORM_NS 400
`define SCT_SYNC_RAC_LOW_NS 500
`define SCT_EOC_BUSY_NS 10
`define SCT_TAIL_NS 13
`define SCT_RST_BUSY_NS 600
`define SCT_SCLK_P0_NS 8
`define SCT_SCLK_P1_NS 16
`define SCT_SCLK_P2_NS 32
`define SCT_SCLK_P3_NS 64
`define SCT_HALF_CYC(p) (((p) + 2 * `SCT_CLK_NS - 1) / (2 * `SCT_CLK_NS))
`define SCT_EOC_CYC `SCT_CYC_CEIL(`SCT_EOC_BUSY_NS)
`define SCT_TAIL_CYC `SCT_CYC_CEIL(`SCT_TAIL_NS)
`define SCT_RST_BUSY_CYC `SCT_CYC_CEIL(`SCT_RST_BUSY_NS)

`endif

// [rtl/sct_pkg.sv]
// Purpose: shared types of the conversion timing block
// Assumes: constants come from sct_defines.svh
// Notes: wideband code shares every timing with the fastest code
package sct_pkg;

	// rate mode straps
	typedef enum logic [1:0] {
		RATE_FAST = 2'h0,
		RATE_NORM = 2'h1,
		RATE_LOW = 2'h2,
		RATE_WIDE = 2'h3
	} sct_rate_t;

	// conversion sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CONV = 3'h1,
		ST_SERIAL = 3'h2,
		ST_TAIL = 3'h3,
		ST_HOLD = 3'h4,
		ST_RSTBUSY = 3'h5
	} sct_state_t;

endpackage

// [rtl/sct_shifter.sv]
// Purpose: result shift register with master serial clock generator
// Assumes: go and load come from the same clock domain
// Notes: data changes on the falling serial clock, host samples on the rising one
`include "sct_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sct_shifter #(
	parameter int WIDTH = `SCT_WORD_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	input wire logic go,
	input wire logic shift_ext,
	input wire logic [2:0] half_cycles,
	input wire logic fill_bit,
	// serial side
	output logic active,
	output logic done,
	output logic sclk,
	output logic sdo
);
	localparam int BW = $clog2(WIDTH) + 1;

	logic active_r, active_nxt;
	logic sclk_r, sclk_nxt;
	logic [2:0] div_r, div_nxt;
	logic [BW-1:0] bits_r, bits_nxt;
	logic [WIDTH-1:0] sh_r, sh_nxt;
	logic [BW-1:0] rises_r;

	// ************************************************************
	// shift and clock generation
	// ************************************************************
	// clock starts low so the first edge trails the frame by half a period
	always_comb begin
		active_nxt = active_r;
		sclk_nxt = sclk_r;
		div_nxt = div_r;
		bits_nxt = bits_r;
		sh_nxt = sh_r;
		done = 1'h0;
		if (go) begin
			active_nxt = 1'h1;
			sclk_nxt = 1'h0;
			div_nxt = 3'h0;
			bits_nxt = '0;
		end else if (active_r) begin
			if (div_r == 3'(half_cycles - 3'h1)) begin
				div_nxt = 3'h0;
				sclk_nxt = ~sclk_r;
				if (sclk_r) begin
					sh_nxt = {sh_r[WIDTH-2:0], fill_bit};
					bits_nxt = BW'(bits_r + 1'h1);
					if (bits_r == BW'(WIDTH - 1)) begin
						active_nxt = 1'h0;
						done = 1'h1;
					end
				end
			end else begin
				div_nxt = 3'(div_r + 3'h1);
			end
		end else if (shift_ext) begin
			sh_nxt = {sh_r[WIDTH-2:0], fill_bit};
		end
		if (load) begin
			sh_nxt = load_data;
		end
	end

	// registers only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_r <= 1'h0;
			sclk_r <= 1'h0;
			div_r <= 3'h0;
			bits_r <= '0;
			sh_r <= '0;
		end else begin
			active_r <= active_nxt;
			sclk_r <= sclk_nxt;
			div_r <= div_nxt;
			bits_r <= bits_nxt;
			sh_r <= sh_nxt;
		end
	end

	assign active = active_r;
	assign sclk = sclk_r;
	assign sdo = sh_r[WIDTH-1];

	// ************************************************************
	// checks
	// ************************************************************
	// helper: rising serial clock edges seen in the current frame
	always_ff @(posedge clk) begin
		if (sys_rst || go) begin
			rises_r <= '0;
		end else if (active_r && sclk_nxt && !sclk_r) begin
			rises_r <= BW'(rises_r + 1'h1);
		end
	end

	frame_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(active_r) |-> rises_r == BW'(WIDTH))
		else $error("frame ended without a full word of clock edges");
	first_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(active_r) |-> !sclk_r)
		else $error("serial clock high at frame start");
	frame_cov: cover property (@(posedge clk) disable iff (sys_rst) $fell(active_r));

endmodule

`default_nettype wire

// [verif/sct_host_model.sv]
// Purpose: host side of the serial port, captures result words
// Assumes: master capture on rising internal clock inside the frame
// Notes: slave clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none

module sct_host_model (
	// clock
	input wire logic clk,
	// mode
	input wire logic master,
	// serial lines from the device
	input wire logic serial_clock_out,
	input wire logic frame_marker_out,
	input wire logic serial_data_out,
	// lines to the device
	output logic ext_sclk,
	output logic serial_data_in,
	// captured word
	output logic [15:0] word,
	output logic [4:0] nbits
);
	wire cap_clk = master ? (serial_clock_out & frame_marker_out) : ext_sclk;

	initial begin
		ext_sclk = 1'b0;
		serial_data_in = 1'b0;
		word = 16'h0000;
		nbits = 5'h00;
	end

	// chain input has no pull, so it toggles every cycle
	always @(posedge clk) begin
		serial_data_in <= ~serial_data_in;
	end

	// sample on the rising edge, msb first
	always @(posedge cap_clk) begin
		word <= {word[14:0], serial_data_out};
		nbits <= nbits + 5'h01;
	end

	task automatic clear();
		word = 16'h0000;
		nbits = 5'h00;
	endtask

	// phases of four cycles leave room for the two-flop sync
	task automatic slave_read();
		repeat (16) begin
			@(negedge clk) ext_sclk = 1'b1;
			repeat (4) @(negedge clk);
			ext_sclk = 1'b0;
			repeat (3) @(negedge clk);
		end
	endtask
endmodule

`default_nettype wire

// [verif/tb.sv]
// Purpose: self-checking bench of the conversion timing block
// Assumes: inputs change on the falling clock edge, except serial_data_in, which the host model toggles on the rising one
// Notes: busy length is counted in whole cycles
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic conversion_start_n = 1'b1;
	logic adc_reset = 1'b0;
	logic [1:0] rate_mode = 2'h0;
	logic serial_en = 1'b0;
	logic master_en = 1'b0;
	logic read_during = 1'b0;
	logic [1:0] serial_clock_divider = 2'h0;
	logic reference_powerdown = 1'b0;
	logic ref_buffer_powerdown = 1'b0;
	logic [15:0] core_code = 16'h0000;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic internal_ref_en, ref_buffer_en, busy, result_valid, par_data_oe;
	logic [15:0] par_data_out, word;
	logic [4:0] nbits;
	logic ext_sclk, serial_data_in, serial_data_out, serial_data_oe;
	logic frame_marker_out, frame_marker_oe, serial_clock_out, serial_clock_oe;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	int n;
	int nexp[4] = '{11, 17, 22, 11};

	always #12.5 clk = ~clk;

	sct_top dut_u (.clk(clk), .sys_rst(sys_rst), .conversion_start_n(conversion_start_n),
		.adc_reset(adc_reset), .rate_mode(rate_mode), .serial_en(serial_en),
		.master_en(master_en), .read_during(read_during),
		.serial_clock_divider(serial_clock_divider), .reference_powerdown(reference_powerdown),
		.ref_buffer_powerdown(ref_buffer_powerdown), .internal_ref_en(internal_ref_en),
		.ref_buffer_en(ref_buffer_en), .core_code(core_code), .busy(busy),
		.result_valid(result_valid), .cs_n(cs_n), .rd_n(rd_n), .par_data_out(par_data_out),
		.par_data_oe(par_data_oe), .ext_sclk(ext_sclk), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.frame_marker_out(frame_marker_out), .frame_marker_oe(frame_marker_oe),
		.serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe));

	sct_host_model host_u (.clk(clk), .master(master_en), .serial_clock_out(serial_clock_out),
		.frame_marker_out(frame_marker_out), .serial_data_out(serial_data_out),
		.ext_sclk(ext_sclk), .serial_data_in(serial_data_in), .word(word), .nbits(nbits));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// start, count busy cycles; a second fall mid-busy must be ignored
	task automatic conv(input logic [1:0] m, input logic [15:0] code, output int cnt);
		@(negedge clk) rate_mode = m;
		core_code = code;
		conversion_start_n = 1'b0;
		cnt = 0;
		@(negedge clk);
		while (busy === 1'b1 && cnt < 2000) begin
			cnt++;
			if (cnt == 3) conversion_start_n = 1'b1;
			if (cnt == 4) conversion_start_n = 1'b0;
			@(negedge clk);
		end
		conversion_start_n = 1'b1;
		repeat (10) @(negedge clk);
	endtask

	task automatic par_read(input logic [15:0] exp);
		@(negedge clk) cs_n = 1'b0;
		rd_n = 1'b0;
		#5 chk(16'(par_data_oe), 16'h0001);
		chk(par_data_out, exp);
		@(negedge clk) rd_n = 1'b1;
		cs_n = 1'b1;
		#5 chk(16'(par_data_oe), 16'h0000);
	endtask

	task automatic oes(input logic [15:0] exp);
		#5 chk({13'h0000, serial_data_oe, frame_marker_oe, serial_clock_oe}, exp);
	endtask

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		chk(16'(busy), 16'h0000);
		chk(16'(result_valid), 16'h0000);
		chk({14'h0000, internal_ref_en, ref_buffer_en}, 16'h0003);
		reference_powerdown = 1'b1;
		repeat (2) @(negedge clk);
		chk({14'h0000, internal_ref_en, ref_buffer_en}, 16'h0001);
		ref_buffer_powerdown = 1'b1;
		repeat (2) @(negedge clk);
		chk({14'h0000, internal_ref_en, ref_buffer_en}, 16'h0000);
		$display("test reference done");
		// host reset then busy for the fixed 600 ns
		adc_reset = 1'b1;
		@(negedge clk) adc_reset = 1'b0;
		n = 0;
		@(negedge clk);
		while (busy === 1'b1 && n < 100) begin
			n++;
			@(negedge clk);
		end
		chk(16'(n), 16'd24);
		$display("test reset busy done");
		// parallel bus, every rate code
		for (int i = 0; i < 4; i++) begin
			conv(2'(i), 16'hA5C3 ^ 16'(i * 16'h1111), n);
			chk(16'(n), 16'(nexp[i]));
			chk(16'(result_valid), 16'h0001);
			par_read(16'hA5C3 ^ 16'(i * 16'h1111));
		end
		$display("test parallel done");
		// master read after, then read during, then wider divider
		@(negedge clk) serial_en = 1'b1;
		master_en = 1'b1;
		cs_n = 1'b0;
		oes(16'h0007);
		host_u.clear();
		conv(2'h0, 16'h8001, n);
		chk(word, 16'h8001);
		chk(16'(nbits), 16'd16);
		read_during = 1'b1;
		host_u.clear();
		conv(2'h1, 16'h3C5A, n);
		// the read-during frame outlives busy, so let it finish first
		repeat (16) @(negedge clk);
		chk(word, 16'h8001);
		chk(16'(n), 16'd17);
		read_during = 1'b0;
		serial_clock_divider = 2'h3;
		host_u.clear();
		conv(2'h2, 16'hF00F, n);
		chk(word, 16'hF00F);
		@(negedge clk) cs_n = 1'b1;
		oes(16'h0000);
		$display("test master serial done");
		// slave read with host clock
		@(negedge clk) master_en = 1'b0;
		cs_n = 1'b0;
		oes(16'h0004);
		conv(2'h3, 16'h6B2D, n);
		host_u.clear();
		host_u.slave_read();
		chk(word, 16'h6B2D);
		@(negedge clk) cs_n = 1'b1;
		oes(16'h0000);
		$display("test slave serial done");
		summarize();
	end
endmodule

`default_nettype wire
